// file: bcrb_top.sv
// board configuration register bank: APB slave with id, revision,
// switch routing and bias registers, plus transceiver window bridge
// assumes APB master on SYS_CLK and straps held stable after reset
//
// Functional notes
// - indices 0x0000-0x0015 hit own registers, 0x1000-0x10ff go to the transceiver.
// - board id at 0x0000 and extended id nibbles at 0x0002-0x0004 read only.
// - fab, assembly and logic revisions read only at 0x0005-0x0007.
// - four read-write switch registers at 0x0011-0x0014 drive FET switches.
// - the t1-rate clock route resets to 0xf, all switches open.
// - bias register at 0x0015 drives a pin high for each bit set to one.
// - a switch field of zero closes the switch, one opens it.
// - the e1-rate clock route resets to 0x3.
`timescale 1ns/1ps
module bcrb_top
   import bcrb_pkg::*;
#(
   // arbitrary neutral identity values
   parameter bcrb_nib_t BOARD_IDENT = 4'h1,
   parameter bcrb_nib_t EXT_HIGH    = 4'h2,
   parameter bcrb_nib_t EXT_MID     = 4'h3,
   parameter bcrb_nib_t EXT_LOW     = 4'h4,
   parameter bcrb_nib_t LOGIC_REV   = 4'h1
)(
   input  wire logic        SYS_CLK,
   input  wire logic        RESETN,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [17:0] PADDR,
   input  wire logic [31:0] PWDATA,
   input  wire logic [3:0]  PSTRB,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   input  wire logic [3:0]  FAB_REV_PINS,
   input  wire logic [3:0]  ASM_REV_PINS,
   output logic [3:0]       ROUTE_T1_SW_OPEN,
   output logic [3:0]       ROUTE_E1_SW_OPEN,
   output logic [3:0]       LINKS_A_SW_OPEN,
   output logic [3:0]       LINKS_B_SW_OPEN,
   output logic [3:0]       BIAS_HIGH,
   output logic             MCLK_CONTENTION,
   output logic             XCVR_SEL,
   output logic             XCVR_WR,
   output logic [7:0]       XCVR_ADDR,
   output logic [7:0]       XCVR_WDATA,
   input  wire logic [7:0]  XCVR_RDATA,
   input  wire logic        XCVR_READY
);
   // --------------------------------------------------------------
   // revision straps
   // --------------------------------------------------------------
   // straps are off-domain pins: two stages before use
   logic [7:0] strap_s1_q;
   logic [7:0] strap_s2_q;
   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         strap_s1_q <= 8'h00;
         strap_s2_q <= 8'h00;
      end else begin
         strap_s1_q <= {ASM_REV_PINS, FAB_REV_PINS};
         strap_s2_q <= strap_s1_q;
      end
   end

   // --------------------------------------------------------------
   // address decode
   // --------------------------------------------------------------
   wire [15:0] idx       = PADDR[17:2];
   wire        setup     = PSEL && !PENABLE;
   wire        in_cfg    = (idx <= `BCRB_CFG_LAST_IDX);
   wire        in_xcvr   = (idx >= `BCRB_XCVR_FIRST_IDX) &&
                           (idx <= `BCRB_XCVR_LAST_IDX);
   wire [7:0]  cfg_idx   = idx[7:0];
   wire        wr_lane   = PSTRB[0];
   wire        cfg_write = PSEL && PENABLE && PWRITE && in_cfg && wr_lane;
   wire        x_start   = setup && in_xcvr;

   function automatic logic is_rw(input logic [7:0] i);
      is_rw = (i >= `BCRB_IDX_ROUTE_T1) && (i <= `BCRB_IDX_BIAS);
   endfunction

   // --------------------------------------------------------------
   // switch and bias registers
   // --------------------------------------------------------------
   bcrb_nib_t t1_q, e1_q, la_q, lb_q, bias_q;
   wire       wr_t1 = cfg_write && cfg_idx == `BCRB_IDX_ROUTE_T1;
   wire       wr_e1 = cfg_write && cfg_idx == `BCRB_IDX_ROUTE_E1;
   wire       wr_la = cfg_write && cfg_idx == `BCRB_IDX_LINKS_A;
   wire       wr_lb = cfg_write && cfg_idx == `BCRB_IDX_LINKS_B;
   wire       wr_bs = cfg_write && cfg_idx == `BCRB_IDX_BIAS;

   always_ff @(posedge SYS_CLK) begin
      if (!RESETN) begin
         t1_q   <= `BCRB_RST_ROUTE_T1;
         e1_q   <= `BCRB_RST_ROUTE_E1;
         la_q   <= `BCRB_RST_LINKS_A;
         lb_q   <= `BCRB_RST_LINKS_B;
         bias_q <= `BCRB_RST_BIAS;
      end else begin
         if (wr_t1) t1_q <= PWDATA[3:0];
         if (wr_e1) e1_q <= PWDATA[3:0];
         if (wr_la) la_q <= PWDATA[3:0];
         if (wr_lb) lb_q <= PWDATA[3:0];
         if (wr_bs) bias_q <= PWDATA[3:0];
      end
   end

   // a one bit leaves the switch open, zero closes it
   assign ROUTE_T1_SW_OPEN = t1_q;
   assign ROUTE_E1_SW_OPEN = e1_q;
   assign LINKS_A_SW_OPEN  = la_q;
   assign LINKS_B_SW_OPEN  = lb_q;
   assign BIAS_HIGH        = bias_q;
   // hardware only flags it; blocking the write would hide the mistake
   assign MCLK_CONTENTION  = !t1_q[`BCRB_MCLK_BIT] &&
                             !e1_q[`BCRB_MCLK_BIT];

   // --------------------------------------------------------------
   // read mux
   // --------------------------------------------------------------
   logic [3:0] cfg_rd;
   always_comb begin
      unique case (cfg_idx)
         `BCRB_IDX_BOARD_IDENT: cfg_rd = BOARD_IDENT;
         `BCRB_IDX_EXT_HIGH:    cfg_rd = EXT_HIGH;
         `BCRB_IDX_EXT_MID:     cfg_rd = EXT_MID;
         `BCRB_IDX_EXT_LOW:     cfg_rd = EXT_LOW;
         `BCRB_IDX_FAB_REV:     cfg_rd = strap_s2_q[3:0];
         `BCRB_IDX_ASM_REV:     cfg_rd = strap_s2_q[7:4];
         `BCRB_IDX_LOGIC_REV:   cfg_rd = LOGIC_REV;
         `BCRB_IDX_ROUTE_T1:    cfg_rd = t1_q;
         `BCRB_IDX_ROUTE_E1:    cfg_rd = e1_q;
         `BCRB_IDX_LINKS_A:     cfg_rd = la_q;
         `BCRB_IDX_LINKS_B:     cfg_rd = lb_q;
         `BCRB_IDX_BIAS:        cfg_rd = bias_q;
         default:               cfg_rd = 4'h0;
      endcase
   end

   // --------------------------------------------------------------
   // transceiver bridge
   // --------------------------------------------------------------
   logic       x_done;
   logic [7:0] x_rd;
   bcrb_xcvr_bridge u_bridge (
      .clk     (SYS_CLK),
      .resetn  (RESETN),
      .start   (x_start),
      .write   (PWRITE),
      .addr    (idx[7:0]),
      .wdata   (PWDATA[7:0]),
      .done    (x_done),
      .rdata   (x_rd),
      .x_sel   (XCVR_SEL),
      .x_wr    (XCVR_WR),
      .x_addr  (XCVR_ADDR),
      .x_wdata (XCVR_WDATA),
      .x_rdata (XCVR_RDATA),
      .x_ready (XCVR_READY)
   );

   // --------------------------------------------------------------
   // apb answer
   // --------------------------------------------------------------
   // own registers answer with no wait; unmapped space errors
   wire unmapped = !in_cfg && !in_xcvr;
   assign PREADY  = PSEL && PENABLE && (in_xcvr ? x_done : 1'b1);
   assign PSLVERR = PSEL && PENABLE && unmapped;

   always_comb begin
      if (in_xcvr)
         PRDATA = {24'h000000, x_rd};
      else if (in_cfg)
         PRDATA = {28'h0000000, cfg_rd};
      else
         PRDATA = 32'h00000000;
   end

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   a_reset_routes: assert property (@(posedge SYS_CLK)
      $rose(RESETN) |-> t1_q == 4'hf && e1_q == 4'h3)
      else $error("route reset values wrong");
   a_t1_write_takes: assert property (@(posedge SYS_CLK)
      disable iff (!RESETN)
      wr_t1 |=> ROUTE_T1_SW_OPEN == $past(PWDATA[3:0]))
      else $error("t1 route write lost");
   a_bias_write_takes: assert property (@(posedge SYS_CLK)
      disable iff (!RESETN)
      wr_bs |=> BIAS_HIGH == $past(PWDATA[3:0]))
      else $error("bias write lost");
   a_unassigned_zero: assert property (@(posedge SYS_CLK)
      disable iff (!RESETN)
      (PSEL && in_cfg && !is_rw(cfg_idx) && cfg_idx > 8'h07)
         |-> PRDATA == 32'h0)
      else $error("unassigned offset not zero");
   a_ident_read: assert property (@(posedge SYS_CLK)
      disable iff (!RESETN)
      (PSEL && in_cfg && cfg_idx == 8'h00)
         |-> PRDATA == {28'h0, BOARD_IDENT})
      else $error("board ident wrong");
   a_route_hold: assert property (@(posedge SYS_CLK)
      disable iff (!RESETN)
      !wr_e1 |=> $stable(e1_q))
      else $error("e1 route changed without write");
   a_xcvr_forward: assert property (@(posedge SYS_CLK)
      disable iff (!RESETN)
      x_start |=> XCVR_SEL && XCVR_ADDR == $past(idx[7:0]))
      else $error("transceiver access not forwarded");
   a_contention_flag: assert property (@(posedge SYS_CLK)
      disable iff (!RESETN)
      MCLK_CONTENTION |-> !ROUTE_T1_SW_OPEN[3] && !ROUTE_E1_SW_OPEN[3])
      else $error("contention flag wrong");
   a_cfg_no_wait: assert property (@(posedge SYS_CLK)
      disable iff (!RESETN)
      (PSEL && PENABLE && in_cfg) |-> PREADY && !PSLVERR)
      else $error("config access stalled");
endmodule

// file: bcrb_cfg.svh
// constants for the board configuration register bank
// assumes inclusion by bare name from the package only; the modules use its macros without including it
`ifndef BCRB_CFG_SVH
`define BCRB_CFG_SVH
// printed offsets are register indices; byte address is index * 4
`define BCRB_IDX_BOARD_IDENT   8'h00
`define BCRB_IDX_EXT_HIGH      8'h02
`define BCRB_IDX_EXT_MID       8'h03
`define BCRB_IDX_EXT_LOW       8'h04
`define BCRB_IDX_FAB_REV       8'h05
`define BCRB_IDX_ASM_REV       8'h06
`define BCRB_IDX_LOGIC_REV     8'h07
`define BCRB_IDX_ROUTE_T1      8'h11
`define BCRB_IDX_ROUTE_E1      8'h12
`define BCRB_IDX_LINKS_A       8'h13
`define BCRB_IDX_LINKS_B       8'h14
`define BCRB_IDX_BIAS          8'h15
// window limits, as indices
`define BCRB_CFG_LAST_IDX      16'h0015
`define BCRB_XCVR_FIRST_IDX    16'h1000
`define BCRB_XCVR_LAST_IDX     16'h10ff
// reset values
`define BCRB_RST_ROUTE_T1      4'hf
`define BCRB_RST_ROUTE_E1      4'h3
`define BCRB_RST_LINKS_A       4'hf
`define BCRB_RST_LINKS_B       4'h3
`define BCRB_RST_BIAS          4'h6
// field position of the master clock switch in both clock routes
`define BCRB_MCLK_BIT          3
`endif

// file: bcrb_pkg.sv
// types for the board configuration register bank
// assumes bcrb_cfg.svh is on the include path
package bcrb_pkg;
   `include "bcrb_cfg.svh"
   typedef logic [3:0] bcrb_nib_t;
   typedef enum logic [2:0] {
      BCRB_IDLE   = 3'b001,
      BCRB_WAIT   = 3'b010,
      BCRB_DONE   = 3'b100
   } bcrb_xst_t;
endpackage

// file: bcrb_xcvr_bridge.sv
// pass-through of host accesses to the transceiver register range
// assumes the transceiver answers with a same-clock ready pulse
`timescale 1ns/1ps
module bcrb_xcvr_bridge
   import bcrb_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic        start,
   input  wire logic        write,
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   output logic             done,
   output logic [7:0]       rdata,
   output logic             x_sel,
   output logic             x_wr,
   output logic [7:0]       x_addr,
   output logic [7:0]       x_wdata,
   input  wire logic [7:0]  x_rdata,
   input  wire logic        x_ready
);
   bcrb_xst_t  st_q;
   bcrb_xst_t  st_d;
   logic [7:0] rdata_q;

   always_comb begin
      st_d = st_q;
      unique case (st_q)
         BCRB_IDLE: if (start) st_d = BCRB_WAIT;
         BCRB_WAIT: if (x_ready) st_d = BCRB_DONE;
         BCRB_DONE: st_d = BCRB_IDLE;
         default:   st_d = BCRB_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         st_q    <= BCRB_IDLE;
         rdata_q <= 8'h00;
         x_wr    <= 1'b0;
         x_addr  <= 8'h00;
         x_wdata <= 8'h00;
      end else begin
         st_q <= st_d;
         if (st_q == BCRB_IDLE && start) begin
            x_wr    <= write;
            x_addr  <= addr;
            x_wdata <= wdata;
         end
         if (st_q == BCRB_WAIT && x_ready)
            rdata_q <= x_rdata;
      end
   end

   assign x_sel = (st_q == BCRB_WAIT);
   assign done  = (st_q == BCRB_DONE);
   assign rdata = rdata_q;
endmodule

// file: bcrb_xcvr_model.sv
// behavioural transceiver register space seen by the bank's bridge
// assumes one access at a time, held until the ready pulse
`timescale 1ns/1ps
module bcrb_xcvr_model (
   input  wire logic       clk,
   input  wire logic [3:0] dly,
   input  wire logic       sel,
   input  wire logic       wr,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   output logic [7:0]      rdata,
   output logic            ready
);
   logic [7:0] mem [256];
   logic [3:0] cnt;
   initial begin
      ready = 1'b0;
      rdata = 8'h00;
      cnt = 4'h0;
      for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
   end
   // read data is only held in the ready cycle; it churns otherwise
   always @(posedge clk) begin
      ready <= 1'b0;
      rdata <= ~rdata;
      if (sel && !ready) begin
         if (cnt == dly) begin
            ready <= 1'b1;
            cnt <= 4'h0;
            rdata <= mem[addr];
            if (wr) mem[addr] <= wdata;
         end else cnt <= cnt + 4'h1;
      end
   end
endmodule

// file: tb.sv
// self-checking bench for the board configuration register bank
// assumes bcrb_pkg, bcrb_top and bcrb_xcvr_model are compiled first
`timescale 1ns/1ps
module tb
   import bcrb_pkg::*;
;
   logic        clk = 0, rstn = 0, psel = 0, pen = 0, pwr = 0;
   logic [17:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0]  pstrb = 4'h1, fab = 4'h7, asm_r = 4'h2, xdly = '0;
   logic [3:0]  t1, e1, la, lb, bias;
   logic        pready, perr, cont, xsel, xwr, xrdy, err;
   logic [7:0]  xaddr, xwd, xrd;
   logic [3:0]  shadow [22];
   int          miscompares = 0, num_checks = 0;
   // negative slot selects the single-slot host board
   int          slot = -1;
   // identity values are arbitrary
   bcrb_top #(.BOARD_IDENT(4'h9), .EXT_HIGH(4'ha), .EXT_MID(4'hb),
      .EXT_LOW(4'hc), .LOGIC_REV(4'he)) bcrb_top_i (
      .SYS_CLK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(pen),
      .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(perr),
      .FAB_REV_PINS(fab), .ASM_REV_PINS(asm_r), .ROUTE_T1_SW_OPEN(t1),
      .ROUTE_E1_SW_OPEN(e1), .LINKS_A_SW_OPEN(la), .LINKS_B_SW_OPEN(lb),
      .BIAS_HIGH(bias), .MCLK_CONTENTION(cont), .XCVR_SEL(xsel),
      .XCVR_WR(xwr), .XCVR_ADDR(xaddr), .XCVR_WDATA(xwd),
      .XCVR_RDATA(xrd), .XCVR_READY(xrdy));
   bcrb_xcvr_model bcrb_xcvr_model_i (.clk(clk), .dly(xdly), .sel(xsel),
      .wr(xwr), .addr(xaddr), .wdata(xwd), .rdata(xrd), .ready(xrdy));
   always #20 clk = ~clk;
   // ---------------------------------------------------------------
   // bus and compare tasks
   // ---------------------------------------------------------------
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // host address is card base plus byte offset; the bank sees the low bits
   function automatic logic [17:0] host_addr(logic [15:0] ix);
      logic [31:0] base;
      base = 32'h81000000;
      if (slot >= 0)
         base = 32'h30000000 + 32'(slot) * 32'h10000000;
      host_addr = 18'(base + {14'h0000, ix, 2'b00});
   endfunction
   // pready, read data and error are all taken at the same rising edge
   task automatic apb(logic w, logic [15:0] ix, logic [31:0] d);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      paddr <= host_addr(ix);
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = perr;
   endtask
   task automatic idle();
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic acc(logic w, logic [15:0] ix, logic [31:0] d);
      apb(w, ix, d);
      idle();
   endtask
   task automatic rst_shadow();
      for (int i = 0; i < 22; i++) shadow[i] = 4'h0;
      shadow[0] = 4'h9; shadow[2] = 4'ha; shadow[3] = 4'hb;
      shadow[4] = 4'hc; shadow[5] = fab; shadow[6] = asm_r;
      shadow[7] = 4'he; shadow[17] = 4'hf; shadow[18] = 4'h3;
      shadow[19] = 4'hf; shadow[20] = 4'h3; shadow[21] = 4'h6;
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_pins();
      chk("route t1", 32'(t1), 32'(shadow[17]));
      chk("route e1", 32'(e1), 32'(shadow[18]));
      chk("links a", 32'(la), 32'(shadow[19]));
      chk("links b", 32'(lb), 32'(shadow[20]));
      chk("bias", 32'(bias), 32'(shadow[21]));
      chk("contention", 32'(cont), 32'h0);
   endtask
   task automatic t_map();
      for (int i = 0; i < 22; i++) begin
         acc(1'b0, 16'(i), '0);
         chk("cfg read", rd, 32'(shadow[i]));
         chk("cfg error", 32'(err), 32'h0);
      end
   endtask
   // every written value keeps bit 3 of one clock route set
   task automatic t_write(logic [3:0] k, logic [3:0] s);
      pstrb <= s;
      for (int i = 0; i < 22; i++) begin
         acc(1'b1, 16'(i), {28'hfffffff, 4'(i) ^ k});
         if (i > 16 && s[0]) shadow[i] = 4'(i) ^ k;
      end
      t_map();
      t_pins();
   endtask
   task automatic t_unmapped();
      logic [15:0] bad [4] = '{16'h0016, 16'h0fff, 16'h1100, 16'hffff};
      for (int j = 0; j < 4; j++) begin
         acc(1'b1, bad[j], 32'h0);
         chk("unmapped error", 32'(err), 32'h1);
      end
      t_map();
      t_pins();
   endtask
   task automatic t_xcvr();
      xdly <= 4'h0;
      acc(1'b1, 16'h1000, 32'h3c);
      chk("xcvr write error", 32'(err), 32'h0);
      apb(1'b0, 16'h0011, '0);
      chk("own after xcvr", rd, 32'(shadow[17]));
      apb(1'b0, 16'h1000, '0);
      chk("xcvr readback", rd, 32'h3c);
      xdly <= 4'h6;
      apb(1'b0, 16'h10ff, '0);
      chk("xcvr slow read", rd, 32'ha5);
      idle();
      acc(1'b0, 16'h1042, '0);
      chk("xcvr read", rd, 32'h18);
      // close both master clock switches on purpose to see the flag
      pstrb <= 4'h1;
      acc(1'b1, 16'h0011, 32'h0);
      acc(1'b1, 16'h0012, 32'h0);
      shadow[17] = 4'h0;
      shadow[18] = 4'h0;
      chk("contention set", 32'(cont), 32'h1);
      chk("route t1 closed", 32'(t1), 32'h0);
   endtask
   // a mid-run reset must restore every route and pick up new straps
   task automatic t_reset();
      fab <= 4'h3;
      asm_r <= 4'hd;
      repeat (3) @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      rst_shadow();
      t_pins();
      t_map();
   endtask
   initial begin
      rst_shadow();
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
      t_pins();
      t_map();
      t_write(4'h8, 4'h1);
      slot = 0;
      t_write(4'hb, 4'hf);
      slot = 3;
      t_write(4'hc, 4'he);
      t_unmapped();
      t_xcvr();
      t_reset();
      stop_test();
   end
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      stop_test();
   end
endmodule
